// File: logic/sar_readout_pkg.sv
// Notes on behaviour
// - Chain select low: shared pin enables output
// - Chain select high: shared pin is chain input
// - Convert rising edge powers core, starts conversion
// - Busy high from start until conversion done
// - Shift result or chain data MSB first
// - Output code is unsigned straight binary
// - Conversion end loads 18-bit code for transfer
// - Acquire, then resolve in 18 binary steps
// - Shifted code belongs to latest conversion
// - Conversion timed by internal oscillator only
// - Core powered down between conversions
// - Restart requests ignored while converting
// - Conversion never lasts longer than 412 ns
// - Data changes on rising edges; MSB held
package sar_readout_pkg;

  // Converter resolution
  localparam int RESULT_WIDTH = 18;
  localparam int BIT_IDX_W    = 5;

  // Conversion timing
  localparam int CLK_SYS_MHZ  = 200;
  localparam int CONV_MAX_NS  = 412;
  localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_SYS_MHZ) / 1000;
  localparam int STEP_CYC     = CONV_MAX_CYC / RESULT_WIDTH;
  localparam int STEP_CNT_W   = 4;
  localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYC - 1);

  // Host-side restart window, informative only
  localparam int RESTART_WINDOW_NS = 40;

  // Serial-clock edge counter and chain history
  localparam int SCK_CNT_W  = 8;
  localparam int RING_LOG   = 5;
  localparam int RING_DEPTH = 1 << RING_LOG;

  // Edges by which the chain slot read trails the edge count; own bits per frame
  localparam logic [SCK_CNT_W-1:0] CHAIN_LAG  = SCK_CNT_W'(RESULT_WIDTH - 1);
  localparam logic [SCK_CNT_W-1:0] OWN_BITS   = SCK_CNT_W'(RESULT_WIDTH);

  // Reset values, first trial code and last bit index
  localparam logic [RESULT_WIDTH-1:0] CODE_ZERO = '0;
  localparam logic [RESULT_WIDTH-1:0] CODE_MSB  = {1'b1, {(RESULT_WIDTH-1){1'b0}}};
  localparam logic [BIT_IDX_W-1:0]    MSB_IDX   = BIT_IDX_W'(RESULT_WIDTH - 1);
  localparam logic [BIT_IDX_W-1:0]    LSB_IDX   = '0;

  // Async input vector layout
  localparam int SYNC_W     = 3;
  localparam int SYNC_CONV  = 0;
  localparam int SYNC_RDCH  = 1;
  localparam int SYNC_CMP   = 2;

  // Conversion sequencer, Gray along acquire-convert-done
  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_DONE    = 2'b11
  } conv_state_t;

endpackage

// File: logic/sar_adc_convert_readout.sv
`timescale 1ns/1ps
module sar_adc_convert_readout
  import sar_readout_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             serial_clock_in,
  input  wire logic             convert_start_in,
  input  wire logic             chain_mode_in,
  input  wire logic             read_enable_or_chain_input_in,
  input  wire logic             comparator_in,
  output logic                  busy_out,
  output logic                  core_power_out,
  output logic                  acquire_out,
  output logic [WIDTH-1:0]      dac_code_out,
  output logic                  sdo_out,
  output logic                  sdo_oe_n_out
);

  // Binary to Gray for the edge counter
  function automatic logic [SCK_CNT_W-1:0] bin2gray(input logic [SCK_CNT_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  // Gray back to binary
  function automatic logic [SCK_CNT_W-1:0] gray2bin(input logic [SCK_CNT_W-1:0] g);
    logic [SCK_CNT_W-1:0] b;
    b = '0;
    for (int i = SCK_CNT_W - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == SCK_CNT_W - 1) ? 1'b0 : b[i+1]);
    end
    gray2bin = b;
  endfunction

  // ---------------- Serial clock domain ----------------
  logic [SCK_CNT_W-1:0]  sck_count_reg;
  logic [SCK_CNT_W-1:0]  sck_count_next;
  logic [SCK_CNT_W-1:0]  sck_gray_reg;
  logic [SCK_CNT_W-1:0]  sck_gray_next;
  logic [RING_DEPTH-1:0] ring_reg;
  logic [RING_DEPTH-1:0] ring_next;

  // Count edges; slot n holds the chain bit taken at edge n
  always_comb begin
    sck_count_next = sck_count_reg + SCK_CNT_W'(1);
    sck_gray_next  = bin2gray(sck_count_next);
    ring_next      = ring_reg;
    ring_next[sck_count_next[RING_LOG-1:0]] = read_enable_or_chain_input_in;
  end

  // Only edges of the link clock move this state
  always_ff @(posedge serial_clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_count_reg <= '0;
      sck_gray_reg  <= '0;
      ring_reg      <= '0;
    end else begin
      sck_count_reg <= sck_count_next;
      sck_gray_reg  <= sck_gray_next;
      ring_reg      <= ring_next;
    end
  end

  // ---------------- Chain history crossing ----------------
  // One two-flop stage per ring slot; a slot is rewritten only once per
  // ring turn, long before the output stage reads it
  wire logic [RING_DEPTH-1:0] ring_stable;

  for (genvar s = 0; s < RING_DEPTH; s++) begin : g_ring_sync
    logic slot_meta_reg;
    logic slot_meta_next;
    logic slot_sync_reg;
    logic slot_sync_next;

    // Stage inputs for this slot
    always_comb begin
      slot_meta_next = ring_reg[s];
      slot_sync_next = slot_meta_reg;
    end

    // Slot synchroniser flops
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        slot_meta_reg <= 1'b0;
        slot_sync_reg <= 1'b0;
      end else begin
        slot_meta_reg <= slot_meta_next;
        slot_sync_reg <= slot_sync_next;
      end
    end

    assign ring_stable[s] = slot_sync_reg;
  end

  // ---------------- Input synchronisers ----------------
  logic [SYNC_W-1:0]    async_meta_reg;
  logic [SYNC_W-1:0]    async_meta_next;
  logic [SYNC_W-1:0]    async_sync_reg;
  logic [SYNC_W-1:0]    async_sync_next;
  logic [SCK_CNT_W-1:0] gray_meta_reg;
  logic [SCK_CNT_W-1:0] gray_meta_next;
  logic [SCK_CNT_W-1:0] gray_sync_reg;
  logic [SCK_CNT_W-1:0] gray_sync_next;
  logic                 chain_meta_reg;
  logic                 chain_meta_next;
  logic                 chain_sync_reg;
  logic                 chain_sync_next;
  logic                 conv_prev_reg;
  logic                 conv_prev_next;

  // Two stages; the Gray count moves one bit per edge
  always_comb begin
    async_meta_next = {comparator_in, read_enable_or_chain_input_in, convert_start_in};
    async_sync_next = async_meta_reg;
    gray_meta_next  = sck_gray_reg;
    gray_sync_next  = gray_meta_reg;
    chain_meta_next = chain_mode_in;
    chain_sync_next = chain_meta_reg;
    conv_prev_next  = async_sync_reg[SYNC_CONV];
  end

  // Synchroniser flops
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      async_meta_reg <= '0;
      async_sync_reg <= '0;
      gray_meta_reg  <= '0;
      gray_sync_reg  <= '0;
      chain_meta_reg <= 1'b0;
      chain_sync_reg <= 1'b0;
      conv_prev_reg  <= 1'b0;
    end else begin
      async_meta_reg <= async_meta_next;
      async_sync_reg <= async_sync_next;
      gray_meta_reg  <= gray_meta_next;
      gray_sync_reg  <= gray_sync_next;
      chain_meta_reg <= chain_meta_next;
      chain_sync_reg <= chain_sync_next;
      conv_prev_reg  <= conv_prev_next;
    end
  end

  logic                 conv_rise;
  logic [SCK_CNT_W-1:0] sck_edges;

  // Rising edge of the synchronised convert input
  assign conv_rise = async_sync_reg[SYNC_CONV] & ~conv_prev_reg;
  assign sck_edges = gray2bin(gray_sync_reg);

  // ---------------- Conversion sequencer ----------------
  conv_state_t           state_reg;
  conv_state_t           state_next;
  logic [STEP_CNT_W-1:0] tick_reg;
  logic [STEP_CNT_W-1:0] tick_next;
  logic [BIT_IDX_W-1:0]  bit_idx_reg;
  logic [BIT_IDX_W-1:0]  bit_idx_next;
  logic [WIDTH-1:0]      trial_reg;
  logic [WIDTH-1:0]      trial_next;
  logic [WIDTH-1:0]      result_reg;
  logic [WIDTH-1:0]      result_next;
  logic [SCK_CNT_W-1:0]  base_reg;
  logic [SCK_CNT_W-1:0]  base_next;
  logic                  busy_reg;
  logic                  busy_next;
  logic                  power_reg;
  logic                  power_next;
  logic                  acquire_reg;
  logic                  acquire_next;

  // ---------------- Conversion length guard ----------------
  // Backstop for the busy limit: should the step timing ever be retuned
  // too long, the sequence is cut short rather than overrun; with the
  // default step time the resolve sequence ends well before it
  localparam int                    CONV_AGE_W    = $clog2(CONV_MAX_CYC + 1);
  localparam logic [CONV_AGE_W-1:0] CONV_AGE_LAST = CONV_AGE_W'(CONV_MAX_CYC - 2); // Room for done cycle

  logic [CONV_AGE_W-1:0] conv_age_reg;
  logic [CONV_AGE_W-1:0] conv_age_next;
  logic                  conv_overrun;

  // Cycles spent resolving; cleared outside the convert state
  always_comb begin
    if (state_reg == ST_CONVERT) begin
      conv_age_next = conv_age_reg + CONV_AGE_W'(1);
    end else begin
      conv_age_next = '0;
    end
  end

  // Guard counter flop
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_age_reg <= '0;
    end else begin
      conv_age_reg <= conv_age_next;
    end
  end

  assign conv_overrun = (conv_age_reg == CONV_AGE_LAST);

  // The step timer stands in for the trimmed internal oscillator
  always_comb begin
    state_next   = state_reg;
    tick_next    = tick_reg;
    bit_idx_next = bit_idx_reg;
    trial_next   = trial_reg;
    result_next  = result_reg;
    base_next    = base_reg;
    busy_next    = busy_reg;
    power_next   = power_reg;
    acquire_next = acquire_reg;
    case (state_reg)
      ST_ACQUIRE: begin
        // Sampling capacitors track the input, core sleeps
        acquire_next = 1'b1;
        power_next   = 1'b0;
        busy_next    = 1'b0;
        if (conv_rise) begin
          state_next   = ST_CONVERT;
          tick_next    = '0;
          bit_idx_next = MSB_IDX;
          trial_next   = CODE_MSB[WIDTH-1:0];
          busy_next    = 1'b1;
          power_next   = 1'b1;
          acquire_next = 1'b0;
        end
      end
      ST_CONVERT: begin
        // Restart requests fall through unseen here
        tick_next = tick_reg + STEP_CNT_W'(1);
        if (tick_reg == STEP_LAST) begin
          tick_next = '0;
          // Comparator low means trial exceeds the sample
          if (!async_sync_reg[SYNC_CMP]) begin
            trial_next[bit_idx_reg] = 1'b0;
          end
          if (bit_idx_reg == LSB_IDX) begin
            state_next = ST_DONE;
          end else begin
            bit_idx_next             = bit_idx_reg - BIT_IDX_W'(1);
            trial_next[bit_idx_next] = 1'b1;
          end
        end
        // Length guard overrides the step sequence
        if (conv_overrun) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        // Plain unsigned code, no offset or sign handling
        result_next  = trial_reg;
        base_next    = sck_edges;
        busy_next    = 1'b0;
        power_next   = 1'b0;
        acquire_next = 1'b1;
        state_next   = ST_ACQUIRE;
      end
      default: begin
        state_next   = ST_ACQUIRE;
        busy_next    = 1'b0;
        power_next   = 1'b0;
        acquire_next = 1'b1;
      end
    endcase
  end

  // Sequencer flops
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg   <= ST_ACQUIRE;
      tick_reg    <= '0;
      bit_idx_reg <= MSB_IDX;
      trial_reg   <= CODE_ZERO[WIDTH-1:0];
      result_reg  <= CODE_ZERO[WIDTH-1:0];
      base_reg    <= '0;
      busy_reg    <= 1'b0;
      power_reg   <= 1'b0;
      acquire_reg <= 1'b1;
    end else begin
      state_reg   <= state_next;
      tick_reg    <= tick_next;
      bit_idx_reg <= bit_idx_next;
      trial_reg   <= trial_next;
      result_reg  <= result_next;
      base_reg    <= base_next;
      busy_reg    <= busy_next;
      power_reg   <= power_next;
      acquire_reg <= acquire_next;
    end
  end

  // ---------------- Serial output ----------------
  logic [SCK_CNT_W-1:0] shift_idx;
  logic [SCK_CNT_W-1:0] chain_slot;
  logic [SCK_CNT_W-1:0] own_bit;
  logic                 sdo_reg;
  logic                 sdo_next;
  logic                 sdo_oe_n_reg;
  logic                 sdo_oe_n_next;

  // Edges seen since the code was loaded; wraps after 2^SCK_CNT_W
  assign shift_idx  = sck_edges - base_reg;
  assign chain_slot = base_reg + shift_idx - CHAIN_LAG;
  assign own_bit    = OWN_BITS - SCK_CNT_W'(1) - shift_idx;

  // Ring slot read was written many edges ago and has crossed two flops
  always_comb begin
    if (shift_idx < OWN_BITS) begin
      sdo_next = result_reg[own_bit[BIT_IDX_W-1:0]];
    end else if (chain_sync_reg) begin
      sdo_next = ring_stable[chain_slot[RING_LOG-1:0]];
    end else begin
      sdo_next = 1'b0;
    end
    // Chain mode drives always; normal mode follows the enable pin
    if (chain_sync_reg) begin
      sdo_oe_n_next = 1'b0;
    end else begin
      sdo_oe_n_next = async_sync_reg[SYNC_RDCH];
    end
  end

  // Output flops; data follows each rising serial edge in a few cycles
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sdo_reg      <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
    end else begin
      sdo_reg      <= sdo_next;
      sdo_oe_n_reg <= sdo_oe_n_next;
    end
  end

  // Every output straight from a flop
  assign busy_out       = busy_reg;
  assign core_power_out = power_reg;
  assign acquire_out    = acquire_reg;
  assign dac_code_out   = trial_reg;
  assign sdo_out        = sdo_reg;
  assign sdo_oe_n_out   = sdo_oe_n_reg;

endmodule

// File: dv/sar_adc_convert_readout_assertions.sv
`timescale 1ns/1ps
module sar_adc_convert_readout_assertions
  import sar_readout_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH
) (
  input wire logic             clk_sys_in,
  input wire logic             rst_n_in,
  input wire logic             serial_clock_in,
  input wire logic             convert_start_in,
  input wire logic             chain_mode_in,
  input wire logic             read_enable_or_chain_input_in,
  input wire logic             busy_out,
  input wire logic             core_power_out,
  input wire logic             acquire_out,
  input wire logic [WIDTH-1:0] dac_code_out,
  input wire logic             sdo_out,
  input wire logic             sdo_oe_n_out
);
  logic [7:0] busy_cnt_reg;
  logic [7:0] busy_cnt_next;

  // Busy length, cleared while idle
  always_comb begin
    busy_cnt_next = busy_out ? busy_cnt_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // Pin edge held through the two sync flops
  sequence conv_start_seen;
    !busy_out && $rose(convert_start_in) ##1 convert_start_in[*2];
  endsequence

  chk_busy_start: assert property (conv_start_seen |-> ##[1:2] busy_out)
    else $error("busy did not follow convert start");
  chk_busy_span: assert property ($fell(busy_out) |-> busy_cnt_reg == 8'h49)
    else $error("busy length wrong");
  chk_busy_bound: assert property (busy_cnt_reg <= 8'h52)
    else $error("conversion too long");
  chk_power_busy: assert property (core_power_out == busy_out)
    else $error("core power not tied to conversion");
  chk_acq_phase: assert property (acquire_out == !busy_out)
    else $error("acquire overlaps conversion");
  chk_dac_msb: assert property ($rose(busy_out) |-> dac_code_out == CODE_MSB)
    else $error("first trial code wrong");
  chk_step_hold: assert property ($rose(busy_out) |=> $stable(dac_code_out)[*3])
    else $error("trial step too short");
  chk_oe_chain: assert property (chain_mode_in[*4] |-> !sdo_oe_n_out)
    else $error("output not driven in chain mode");
  chk_oe_normal: assert property ((!chain_mode_in && $stable(read_enable_or_chain_input_in))[*4]
    |-> sdo_oe_n_out == read_enable_or_chain_input_in)
    else $error("output enable not following pin");
  chk_sdo_quiet: assert property ((!serial_clock_in && !busy_out)[*8] |-> $stable(sdo_out))
    else $error("data moved without serial edge");
endmodule

bind sar_adc_convert_readout sar_adc_convert_readout_assertions #(.WIDTH(WIDTH)) chk (
  .clk_sys_in, .rst_n_in, .serial_clock_in, .convert_start_in, .chain_mode_in,
  .read_enable_or_chain_input_in, .busy_out, .core_power_out, .acquire_out,
  .dac_code_out, .sdo_out, .sdo_oe_n_out);

// File: dv/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input  wire logic        go_in,
  input  wire logic [17:0] up_in,
  input  wire logic        sdo_in,
  output logic             sck_out,
  output logic             sdi_out,
  output logic [35:0]      bits_out,
  output logic             done_out
);
  // Clock only inside frames; idle data line flips so no stale bit survives
  initial begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    bits_out = '0;
    done_out = 1'b0;
    forever begin
      @(posedge go_in);
      done_out = 1'b0;
      #7.3;
      for (int i = 0; i < 36; i++) begin
        sdi_out = (i < 18) ? up_in[17-i] : ~sdi_out;
        #40;
        bits_out = {bits_out[34:0], sdo_in};
        sck_out = 1'b1;
        #40;
        sck_out = 1'b0;
      end
      sdi_out = ~sdi_out;
      done_out = 1'b1;
    end
  end
endmodule

// File: dv/test_sar_adc_convert_and_serial_readout.sv
`timescale 1ns/1ps
module test_sar_adc_convert_and_serial_readout;
  import sar_readout_pkg::*;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, convert_start_in = 1'b0;
  logic chain_mode_in = 1'b0, oe_n_drv = 1'b1, go = 1'b0;
  logic [17:0] sample = '0, upstream = '0;
  logic serial_clock_in, sdi, done, busy_out, core_power_out, acquire_out, sdo_out, sdo_oe_n_out;
  logic pin, cmp, sdo_line;
  logic [35:0] bits;
  logic [RESULT_WIDTH-1:0] dac_code_out;
  int failures = 0, comparisons = 0;

  // Shared pin and an ideal comparator against the held sample
  assign pin = chain_mode_in ? sdi : oe_n_drv;
  assign cmp = sample >= dac_code_out;
  // Released output reads inverted, so frames only pass while driven
  assign sdo_line = sdo_oe_n_out ? ~sdo_out : sdo_out;

  sar_adc_convert_readout dut (.clk_sys_in, .rst_n_in, .serial_clock_in, .convert_start_in,
    .chain_mode_in, .read_enable_or_chain_input_in(pin), .comparator_in(cmp), .busy_out,
    .core_power_out, .acquire_out, .dac_code_out, .sdo_out, .sdo_oe_n_out);
  host_link_model host (.go_in(go), .up_in(upstream), .sdo_in(sdo_line), .sck_out(serial_clock_in),
    .sdi_out(sdi), .bits_out(bits), .done_out(done));

  initial forever #2.5 clk_sys_in = ~clk_sys_in;

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait on busy or frame end
  task automatic wait_for(input logic on_done, input logic lvl, input int lim, output int n);
    n = 0;
    while ((on_done ? done : busy_out) !== lvl) begin
      @(negedge clk_sys_in);
      n++;
      if (n > lim) begin
        failures++;
        test_done();
      end
    end
  endtask

  // Restart toggles kept inside the allowed early window must change nothing
  task automatic convert(input logic [17:0] s);
    int n;
    sample = s;
    @(negedge clk_sys_in) convert_start_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    check("busy power acq", {busy_out, core_power_out, acquire_out}, 36'h6);
    repeat (2) @(negedge clk_sys_in) convert_start_in = ~convert_start_in;
    wait_for(1'b0, 1'b0, 100, n);
    check("conv cycles", (n + 7 > 72) && (n + 7 <= 82), 1'b1);
    convert_start_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
  endtask

  task automatic frame(input logic [17:0] up);
    int n;
    upstream = up;
    go = 1'b1;
    @(negedge clk_sys_in) go = 1'b0;
    wait_for(1'b1, 1'b1, 700, n);
  endtask

  // Pin gates the driver only in normal mode
  task automatic test_enable;
    chain_mode_in = 1'b0;
    oe_n_drv = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    check("oe off", sdo_oe_n_out, 1'b1);
    oe_n_drv = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    check("oe on", sdo_oe_n_out, 1'b0);
  endtask

  // Scale ends and a mix; bits past the own 18 are zero
  task automatic test_codes;
    logic [17:0] tbl [3] = '{18'h00000, 18'h3ffff, 18'h2a5c3};
    foreach (tbl[i]) begin
      convert(tbl[i]);
      frame(18'h15555);
      check("normal frame", bits, {tbl[i], 18'h0});
    end
  endtask

  // Upstream word trails own result
  task automatic test_chain;
    chain_mode_in = 1'b1;
    convert(18'h1b3c5);
    frame(18'h2d0f1);
    check("chain frame", bits, {18'h1b3c5, 18'h2d0f1});
    check("chain oe", sdo_oe_n_out, 1'b0);
  endtask

  initial begin
    repeat (5) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    test_enable();
    test_codes();
    test_chain();
    test_enable();
    test_done();
  end
endmodule
